// ==== common/instr_dec_regs.vh ====
// field positions, widths and timing constants of the instruction word decoder
`ifndef INSTR_DEC_REGS_VH
`define INSTR_DEC_REGS_VH
`define IW_WIDTH 14
`define IW_MSB 13
// byte-oriented layout
`define BYTE_OP_LSB 8
`define BYTE_DEST_BIT 7
`define FILE_MSB 6
`define FILE_WIDTH 7
// bit-oriented layout
`define BIT_OP_LSB 10
`define BITNUM_MSB 9
`define BITNUM_LSB 7
`define BITNUM_WIDTH 3
// literal and control layout
`define LIT_MSB 7
`define LIT_WIDTH 8
`define JUMP_OP_LSB 11
`define JUMP_ADDR_MSB 10
`define JUMP_ADDR_WIDTH 11
// group codes in bits 13..12
`define GRP_BYTE 2'h0
`define GRP_BIT 2'h1
`define GRP_JUMP 2'h2
`define GRP_LIT 2'h3
// bit-oriented sub-opcodes in bits 11..10
`define BITOP_CLR 2'h0
`define BITOP_SET 2'h1
`define BITOP_TSTC 2'h2
`define BITOP_TSTS 2'h3
// byte-oriented skip opcodes in bits 13..8
`define OP_DECSKIP 6'h0B
`define OP_INCSKIP 6'h0F
// control words with a fixed code
`define CW_RETURN 14'h0008
`define CW_RETINT 14'h0009
// literal return opcode in bits 13..10
`define OP_RETLIT 4'hD
// timing, and the destination-bit value that selects W
`define OSC_PER_ICYC 2'h3
`define PHASE_RST 2'h0
`define DEST_W 1'h0
`endif

// ==== testbench/prog_mem_model.sv ====
// program memory model feeding words to the decoder
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
(
   input wire clk_in,
   input wire rstn_in,
   input wire fetch_in,
   output logic [13:0] instr_out,
   output logic test_true_out
);
   logic [13:0] rom [0:31];
   logic tst [0:31];
   logic [4:0] pc_r = 5'h00;
   // outside the fetch cycle the bus toggles so a stale word cannot pass
   always @(negedge clk_in)
   begin
      instr_out <= fetch_in ? rom[pc_r] : ~instr_out;
      test_true_out <= fetch_in ? tst[pc_r] : ~test_true_out;
   end
   // step to the next word at each taken fetch
   always @(posedge clk_in)
      pc_r <= !rstn_in ? 5'h00 : pc_r + {4'h0, fetch_in};
endmodule // prog_mem_model
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking testbench for the instruction word decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_in, rstn_in, test_true_in, fetch_out, icyc_end_out, is_byte_out, is_bit_out, is_literal_out;
   logic is_jump_out, dest_file_out, dest_w_out, two_cycle_out, nop_cycle_out;
   logic [13:0] instr_in;
   logic [5:0] byte_opcode_out;
   logic [3:0] bit_opcode_out;
   logic [2:0] jump_opcode_out, bit_num_out;
   logic [6:0] file_addr_out;
   logic [7:0] bit_mask_out, literal_out;
   logic [10:0] jump_addr_out;
   int n_errors = 0, samples_checked = 0, ptr = 0, cycles = 0;
   instruction_word_decoder dut (.*);
   prog_mem_model pm (.clk_in(clk_in), .rstn_in(rstn_in), .fetch_in(fetch_out), .instr_out(instr_in),
      .test_true_out(test_true_in));
   // load one word ahead of its fetch, wait for its decode, compare with word e
   task step(input logic [13:0] w, input logic t, input logic [13:0] e, input logic [7:0] f);
      int i;
      pm.rom[ptr] = w;
      pm.tst[ptr] = t;
      ptr++;
      for (i = 0; i < 8 && icyc_end_out !== 1'b1; i++)
         @(negedge clk_in);
      samples_checked++;
      if ({byte_opcode_out, bit_opcode_out, jump_opcode_out, is_byte_out, is_bit_out, is_literal_out, is_jump_out,
         dest_file_out, dest_w_out, two_cycle_out, nop_cycle_out, file_addr_out, bit_num_out, bit_mask_out,
         literal_out, jump_addr_out} !==
         {e[13:8], e[13:10], e[13:11], f, e[6:0], e[9:7], 8'h01 << e[9:7], e[7:0], e[10:0]})
      begin
         $display("unexpected at %0t: word %h", $time, w);
         n_errors++;
      end
      @(negedge clk_in);
   endtask
   // both destinations, top file address, a true skip and its no-op
   task t_byte;
      step(14'h0787, 1'b0, 14'h0787, 8'h88);
      step(14'h0707, 1'b0, 14'h0707, 8'h84);
      step(14'h0BFF, 1'b1, 14'h0BFF, 8'h8A);
      step(14'h0000, 1'b0, 14'h0BFF, 8'h01);
   endtask
   // bit numbers, a false and a true bit test
   task t_bit;
      step(14'h1B80, 1'b0, 14'h1B80, 8'h40);
      step(14'h1600, 1'b0, 14'h1600, 8'h40);
      step(14'h1F80, 1'b1, 14'h1F80, 8'h42);
      step(14'h0000, 1'b0, 14'h1F80, 8'h01);
   endtask
   // literals with either don't-care value, then call and goto
   task t_lit;
      step(14'h3055, 1'b0, 14'h3055, 8'h20);
      step(14'h3355, 1'b0, 14'h3355, 8'h20);
      step(14'h2005, 1'b0, 14'h2005, 8'h12);
      step(14'h3055, 1'b0, 14'h2005, 8'h01);
      step(14'h2FFF, 1'b0, 14'h2FFF, 8'h12);
   endtask
   // returns, literal return and a true increment-skip, each followed by its no-op
   task t_ctl;
      step(14'h0000, 1'b0, 14'h2FFF, 8'h01);
      step(14'h0008, 1'b0, 14'h0008, 8'h86);
      step(14'h0000, 1'b0, 14'h0008, 8'h01);
      step(14'h0009, 1'b0, 14'h0009, 8'h86);
      step(14'h0000, 1'b0, 14'h0009, 8'h01);
      step(14'h3455, 1'b0, 14'h3455, 8'h22);
      step(14'h0000, 1'b0, 14'h3455, 8'h01);
      step(14'h0F05, 1'b1, 14'h0F05, 8'h86);
      step(14'h0000, 1'b1, 14'h0F05, 8'h01);
      step(14'h0F05, 1'b0, 14'h0F05, 8'h84);
   endtask
   task results;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // clock
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // hang guard, far beyond the 23 instruction cycles (about 100 clocks) the scenarios need
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_errors++;
         results;
      end
   end
   // main sequence
   initial
   begin
      rstn_in = 1'b0;
      repeat (5) @(negedge clk_in);
      rstn_in = 1'b1;
      t_byte;
      t_bit;
      t_lit;
      t_ctl;
      results;
   end
endmodule // tb
`default_nettype wire

// ==== testbench/word_dec_checker.sv ====
// assertions on the instruction word decoder ports
`timescale 1ns/1ps
`default_nettype none
module word_dec_checker
(
   input wire clk_in,
   input wire rstn_in,
   input wire [13:0] instr_in,
   input wire test_true_in,
   input wire fetch_out,
   input wire icyc_end_out,
   input wire is_byte_out,
   input wire is_bit_out,
   input wire is_literal_out,
   input wire is_jump_out,
   input wire dest_file_out,
   input wire dest_w_out,
   input wire [6:0] file_addr_out,
   input wire [7:0] bit_mask_out,
   input wire [7:0] literal_out,
   input wire [10:0] jump_addr_out,
   input wire two_cycle_out,
   input wire nop_cycle_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // a word is only decoded when the one before did not claim a second cycle
   wire take = fetch_out && !two_cycle_out;
   wire [1:0] grp = instr_in[13:12];
   sequence s_gap;
      !fetch_out [*3] ##1 fetch_out;
   endsequence
   AST_PERIOD: assert property (fetch_out |=> s_gap) else $error("fetch spacing");
   AST_ICYC: assert property (fetch_out |=> icyc_end_out) else $error("no cycle end");
   AST_BYTE: assert property (take && grp == 2'h0 |=> is_byte_out && dest_file_out != dest_w_out
      && dest_file_out == $past(instr_in[7]) && file_addr_out == $past(instr_in[6:0])) else $error("byte");
   AST_BIT: assert property (take && grp == 2'h1 |=> is_bit_out
      && bit_mask_out == (8'h01 << $past(instr_in[9:7]))) else $error("bit");
   AST_LIT: assert property (take && grp == 2'h3 |=> is_literal_out
      && literal_out == $past(instr_in[7:0])) else $error("literal");
   AST_JUMP: assert property (take && grp == 2'h2 |=> is_jump_out && two_cycle_out
      && jump_addr_out == $past(instr_in[10:0])) else $error("jump");
   AST_NOP: assert property (fetch_out && two_cycle_out |=> nop_cycle_out && !two_cycle_out) else $error("nop");
   AST_SKIP: assert property (take && instr_in[13:8] == 6'h0B |=> two_cycle_out == $past(test_true_in))
      else $error("skip");
   AST_HOLD: assert property (icyc_end_out |=> $stable(file_addr_out) [*3]) else $error("hold");
endmodule // word_dec_checker
bind instruction_word_decoder word_dec_checker chk_i (.*);
`default_nettype wire

// ==== verilog/instruction_word_decoder.v ====
// instruction word decoder: field split, destination select and cycle length
`timescale 1ns/1ps
`default_nettype none
`include "instr_dec_regs.vh"

module instruction_word_decoder
(
   input wire clk_in,
   input wire rstn_in,
   input wire [`IW_MSB:0] instr_in,
   input wire test_true_in,
   output wire fetch_out,
   output reg icyc_end_out,
   output reg [5:0] byte_opcode_out,
   output reg [3:0] bit_opcode_out,
   output reg [2:0] jump_opcode_out,
   output reg is_byte_out,
   output reg is_bit_out,
   output reg is_literal_out,
   output reg is_jump_out,
   output reg dest_file_out,
   output reg dest_w_out,
   output reg [`FILE_MSB:0] file_addr_out,
   output reg [`BITNUM_WIDTH-1:0] bit_num_out,
   output reg [7:0] bit_mask_out,
   output reg [`LIT_MSB:0] literal_out,
   output reg [`JUMP_ADDR_MSB:0] jump_addr_out,
   output reg two_cycle_out,
   output reg nop_cycle_out
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // one-hot bit select, used for the mask and kept as a function for reuse
   function [7:0] bit_onehot;
      input [`BITNUM_WIDTH-1:0] n;
      begin
         bit_onehot = 8'h01 << n;
      end
   endfunction

   // ---------------------------------------------------------------
   // instruction cycle phase
   // ---------------------------------------------------------------
   reg [1:0] phase_r;
   wire phase_last;

   // four oscillator periods make one instruction cycle
   assign phase_last = (phase_r == `OSC_PER_ICYC);

   always @(posedge clk_in)
   begin
      if (!rstn_in)
         phase_r <= `PHASE_RST;
      else
         phase_r <= phase_r + 2'h1;
   end

   // a new word is taken at the last phase of each cycle
   assign fetch_out = phase_last;

   // ---------------------------------------------------------------
   // combinational decode of the incoming word
   // ---------------------------------------------------------------
   wire [1:0] grp;
   wire is_byte;
   wire is_bit;
   wire is_jump;
   wire is_lit;
   wire byte_skip;
   wire bit_test;
   wire pc_change;
   wire ctl_return;

   // the top two bits split the word into its groups; operand bits
   // are looked at only by the whole-word return match, so don't-care positions have no effect
   assign grp = instr_in[`IW_MSB:`IW_MSB-1];
   assign is_byte = (grp == `GRP_BYTE);
   assign is_bit = (grp == `GRP_BIT);
   assign is_jump = (grp == `GRP_JUMP);
   assign is_lit = (grp == `GRP_LIT);

   // conditional-skip and branching classes
   assign byte_skip = is_byte && ((instr_in[`IW_MSB:`BYTE_OP_LSB] == `OP_DECSKIP) ||
                      (instr_in[`IW_MSB:`BYTE_OP_LSB] == `OP_INCSKIP));
   assign bit_test = is_bit && ((instr_in[`BIT_OP_LSB+1:`BIT_OP_LSB] == `BITOP_TSTC) ||
                     (instr_in[`BIT_OP_LSB+1:`BIT_OP_LSB] == `BITOP_TSTS));
   assign ctl_return = (instr_in == `CW_RETURN) || (instr_in == `CW_RETINT);
   assign pc_change = is_jump || ctl_return ||
                      (is_lit && (instr_in[`IW_MSB:`BIT_OP_LSB] == `OP_RETLIT));

   // ---------------------------------------------------------------
   // registered decode outputs, loaded once per instruction cycle
   // ---------------------------------------------------------------
   // the cycle after a two-cycle word is forced to a no-operation so the
   // prefetched word is discarded rather than executed
   always @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         icyc_end_out <= 1'h0;
         byte_opcode_out <= 6'h00;
         bit_opcode_out <= 4'h0;
         jump_opcode_out <= 3'h0;
         is_byte_out <= 1'h0;
         is_bit_out <= 1'h0;
         is_literal_out <= 1'h0;
         is_jump_out <= 1'h0;
         dest_file_out <= 1'h0;
         dest_w_out <= 1'h0;
         file_addr_out <= 7'h00;
         bit_num_out <= 3'h0;
         bit_mask_out <= 8'h00;
         literal_out <= 8'h00;
         jump_addr_out <= 11'h000;
         two_cycle_out <= 1'h0;
         nop_cycle_out <= 1'h0;
      end
      else
      begin
         icyc_end_out <= phase_last;
         if (phase_last)
         begin
            if (two_cycle_out && !nop_cycle_out)
            begin
               // second cycle runs as a no-operation
               nop_cycle_out <= 1'h1;
               two_cycle_out <= 1'h0;
               is_byte_out <= 1'h0;
               is_bit_out <= 1'h0;
               is_literal_out <= 1'h0;
               is_jump_out <= 1'h0;
               dest_file_out <= 1'h0;
               dest_w_out <= 1'h0;
            end
            else
            begin
               nop_cycle_out <= 1'h0;
               is_byte_out <= is_byte;
               is_bit_out <= is_bit;
               is_literal_out <= is_lit;
               is_jump_out <= is_jump;
               byte_opcode_out <= instr_in[`IW_MSB:`BYTE_OP_LSB];
               bit_opcode_out <= instr_in[`IW_MSB:`BIT_OP_LSB];
               jump_opcode_out <= instr_in[`IW_MSB:`JUMP_OP_LSB];
               // destination bit only steers byte operations
               dest_file_out <= is_byte && instr_in[`BYTE_DEST_BIT];
               dest_w_out <= is_byte && (instr_in[`BYTE_DEST_BIT] == `DEST_W);
               file_addr_out <= instr_in[`FILE_MSB:0];
               bit_num_out <= instr_in[`BITNUM_MSB:`BITNUM_LSB];
               bit_mask_out <= bit_onehot(instr_in[`BITNUM_MSB:`BITNUM_LSB]);
               literal_out <= instr_in[`LIT_MSB:0];
               jump_addr_out <= instr_in[`JUMP_ADDR_MSB:0];
               // test outcome arrives with the word from the datapath
               two_cycle_out <= pc_change || ((byte_skip || bit_test) && test_true_in);
            end
         end
      end
   end

endmodule // instruction_word_decoder
`default_nettype wire
